// file: hw/dtmfcs_pkg.sv
/*
 Shared constants, types and the tone-pair code table for the tone-pair
 code steering serializer. Assumes a 50 MHz core clock.
*/
package dtmfcs_pkg;
   // Clock and timing
   localparam int CLK_HZ = 50_000_000;
   localparam int CLK_MHZ = 50;
   localparam int PRESENCE_DETECT_TIME_US = 12000;
   localparam int ABSENCE_DETECT_TIME_US = 5000;
   localparam int PRESENCE_CYCLES = PRESENCE_DETECT_TIME_US * CLK_MHZ;
   localparam int ABSENCE_CYCLES = ABSENCE_DETECT_TIME_US * CLK_MHZ;
   localparam int TIMER_W = 20;
   // Tone bands
   localparam int ROW_HZ [4] = '{697, 770, 852, 941};
   localparam int COL_HZ [4] = '{1209, 1336, 1477, 1633};
   localparam int BAND_TOL_PCT = 3;
   localparam int PCT = 100;
   localparam int TONE_LOST_HZ = 600;
   localparam int TONE_TIMEOUT = CLK_HZ / TONE_LOST_HZ;
   localparam int PERIOD_W = 17;
   localparam int GROUPS = 2;
   localparam int GRP_ROW = 0;
   localparam int GRP_COL = 1;
   // Code and shifter
   localparam int CODE_W = 4;
   localparam logic [2:0] LAST_BIT = 3'h3;
   localparam logic [2:0] FIRST_SHIFT = 3'h1;
   // Register bus
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] REG_MASK = 8'h08;
   localparam logic [ADDR_W-1:0] REG_CODE = 8'h0C;
   localparam int CTRL_EN_BIT = 0;
   localparam logic CTRL_RESET = 1'b1;
   localparam int EV_W = 4;
   localparam int EV_RISE = 0;
   localparam int EV_FALL = 1;
   localparam int EV_DONE = 2;
   localparam int EV_IGNORED = 3;
   localparam logic [EV_W-1:0] EV_NONE = 4'h0;
   localparam int CODE_STEER_BIT = 4;
   localparam int CODE_CNT_LSB = 8;

   typedef struct packed {
      logic valid;
      logic [1:0] idx;
   } dtmfcs_tone_t;

   typedef enum {ST_LOW, ST_HIGH} dtmfcs_steer_t;
   typedef enum {SH_WAIT, SH_ARMED, SH_SHIFT} dtmfcs_shift_t;

   // Row-major tone pair to 4-bit code
   function automatic logic [CODE_W-1:0] tone2code(input logic [1:0] row,
                                                   input logic [1:0] col);
      logic [CODE_W-1:0] tbl [16];
      tbl = '{4'h1, 4'h2, 4'h3, 4'hD,
              4'h4, 4'h5, 4'h6, 4'hE,
              4'h7, 4'h8, 4'h9, 4'hF,
              4'hB, 4'hA, 4'hC, 4'h0};
      return tbl[{row, col}];
   endfunction
endpackage

// file: hw/dtmfcs_top.sv
/*
 Digital back end of a tone-pair signalling receiver: period-based tone
 detector, code converter, early-steering timer, acknowledge-clocked
 serial shifter, register port and interrupt.
 Assumes squared row/column tones and the acknowledge pin arrive
 asynchronously, and a single-cycle strobe register master on CORE_CLK.
*/
`timescale 1ns/1ps

module dtmfcs_top
   import dtmfcs_pkg::*;
#(
   parameter int PRES_CYC = PRESENCE_CYCLES,
   parameter int ABS_CYC = ABSENCE_CYCLES
)
(
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   // Squared tones and acknowledge pin
   input wire logic ROW_TONE,
   input wire logic COL_TONE,
   input wire logic ACK,
   // Register port
   input wire logic [ADDR_W-1:0] ADDR,
   input wire logic [DATA_W-1:0] WR_DATA,
   input wire logic WR_STB,
   input wire logic RD_STB,
   output logic [DATA_W-1:0] RD_DATA,
   // Link outputs and interrupt
   output logic EARLY_STEER_OUT,
   output logic SERIAL_CODE_OUT,
   output logic IRQ
);

   logic [GROUPS-1:0] tone_s1, tone_s2, tone_prev;
   logic [PERIOD_W-1:0] per_cnt [GROUPS];
   dtmfcs_tone_t tone [GROUPS];
   logic ack_s1, ack_s2, ack_prev, ack_rise;
   logic ctrl_en, detect;
   logic [CODE_W-1:0] code;
   logic code_ready, code_changed;
   dtmfcs_steer_t st_state;
   logic [TIMER_W-1:0] st_cnt;
   logic steer_rise, steer_fall;
   dtmfcs_shift_t sh_state;
   logic [CODE_W-1:0] shreg;
   logic [2:0] bit_cnt;
   logic ev_done, ev_ignored;
   logic [EV_W-1:0] status, mask, ev_set;
   logic status_clr;
   logic [TIMER_W-1:0] det_run, abs_run;

   // Period in cycles matched against each nominal band
   function automatic dtmfcs_tone_t classify(input logic [PERIOD_W-1:0] p,
                                             input logic col);
      dtmfcs_tone_t res;
      int nom;
      res = '0;
      for (int i = 0; i < 4; i++)
      begin
         nom = CLK_HZ / (col ? COL_HZ[i] : ROW_HZ[i]);
         if (int'(p) >= nom * (PCT - BAND_TOL_PCT) / PCT &&
             int'(p) <= nom * (PCT + BAND_TOL_PCT) / PCT)
         begin
            res.valid = 1'b1;
            res.idx = 2'(i);
         end
      end
      return res;
   endfunction

   // Pin synchronisers
   always_ff @(posedge CORE_CLK)
   begin
      if (SYS_RST)
      begin
         tone_s1 <= '0;
         tone_s2 <= '0;
         tone_prev <= '0;
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
         ack_prev <= 1'b0;
      end
      else
      begin
         tone_s1 <= {COL_TONE, ROW_TONE};
         tone_s2 <= tone_s1;
         tone_prev <= tone_s2;
         ack_s1 <= ACK;
         ack_s2 <= ack_s1;
         ack_prev <= ack_s2;
      end
   end

   assign ack_rise = ack_s2 & ~ack_prev;

   // Tone period measurement per group
   always_ff @(posedge CORE_CLK)
   begin
      for (int g = 0; g < GROUPS; g++)
      begin
         if (SYS_RST)
         begin
            per_cnt[g] <= '0;
            tone[g] <= '0;
         end
         else if (tone_s2[g] && !tone_prev[g])
         begin
            tone[g] <= classify(per_cnt[g], g == GRP_COL);
            per_cnt[g] <= '0;
         end
         else if (int'(per_cnt[g]) >= TONE_TIMEOUT)
            tone[g] <= '0;
         else
            per_cnt[g] <= per_cnt[g] + 1'b1;
      end
   end

   assign detect = ctrl_en & tone[GRP_ROW].valid & tone[GRP_COL].valid;

   // Code converter
   always_ff @(posedge CORE_CLK)
   begin
      if (SYS_RST)
      begin
         code <= '0;
         code_ready <= 1'b0;
      end
      else
      begin
         code_ready <= detect;
         if (detect)
            code <= tone2code(tone[GRP_ROW].idx, tone[GRP_COL].idx);
      end
   end

   assign code_changed = detect &&
      (code != tone2code(tone[GRP_ROW].idx, tone[GRP_COL].idx));

   // Steering timer
   assign steer_rise = (st_state == ST_LOW) && detect && code_ready &&
      !code_changed && (int'(st_cnt) >= PRES_CYC - 1);
   assign steer_fall = (st_state == ST_HIGH) && !detect &&
      (int'(st_cnt) >= ABS_CYC - 1);

   always_ff @(posedge CORE_CLK)
   begin
      if (SYS_RST)
      begin
         st_state <= ST_LOW;
         st_cnt <= '0;
         EARLY_STEER_OUT <= 1'b0;
      end
      else
      begin
         unique case (st_state)
            ST_LOW:
            begin
               if (steer_rise)
               begin
                  st_state <= ST_HIGH;
                  st_cnt <= '0;
                  EARLY_STEER_OUT <= 1'b1;
               end
               else if (detect && code_ready && !code_changed)
                  st_cnt <= st_cnt + 1'b1;
               else
                  st_cnt <= '0;
            end
            ST_HIGH:
            begin
               if (steer_fall)
               begin
                  st_state <= ST_LOW;
                  st_cnt <= '0;
                  EARLY_STEER_OUT <= 1'b0;
               end
               else if (!detect)
                  st_cnt <= st_cnt + 1'b1;
               else
                  st_cnt <= '0;
            end
         endcase
      end
   end

   // Acknowledge-clocked serial shifter
   always_ff @(posedge CORE_CLK)
   begin
      if (SYS_RST)
      begin
         sh_state <= SH_WAIT;
         shreg <= '0;
         bit_cnt <= '0;
         SERIAL_CODE_OUT <= 1'b0;
         ev_done <= 1'b0;
         ev_ignored <= 1'b0;
      end
      else
      begin
         ev_done <= 1'b0;
         ev_ignored <= 1'b0;
         if (steer_rise)
         begin
            sh_state <= SH_ARMED;
            bit_cnt <= '0;
         end
         else if (ack_rise && !EARLY_STEER_OUT)
            ev_ignored <= 1'b1;
         else if (ack_rise)
         begin
            unique case (sh_state)
               SH_ARMED:
               begin
                  shreg <= code;
                  SERIAL_CODE_OUT <= code[0];
                  bit_cnt <= FIRST_SHIFT;
                  sh_state <= SH_SHIFT;
               end
               SH_SHIFT:
               begin
                  SERIAL_CODE_OUT <= shreg[bit_cnt[1:0]];
                  bit_cnt <= bit_cnt + 1'b1;
                  if (bit_cnt == LAST_BIT)
                  begin
                     sh_state <= SH_WAIT;
                     ev_done <= 1'b1;
                  end
               end
               SH_WAIT:
                  ev_ignored <= 1'b1;
            endcase
         end
      end
   end

   // Register port and interrupt
   assign status_clr = RD_STB && (ADDR == REG_STATUS);
   always_comb
   begin
      ev_set = EV_NONE;
      ev_set[EV_RISE] = steer_rise;
      ev_set[EV_FALL] = steer_fall;
      ev_set[EV_DONE] = ev_done;
      ev_set[EV_IGNORED] = ev_ignored;
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (SYS_RST)
      begin
         ctrl_en <= CTRL_RESET;
         mask <= EV_NONE;
      end
      else if (WR_STB && ADDR == REG_CTRL)
         ctrl_en <= WR_DATA[CTRL_EN_BIT];
      else if (WR_STB && ADDR == REG_MASK)
         mask <= WR_DATA[EV_W-1:0];
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (SYS_RST)
      begin
         status <= EV_NONE;
         IRQ <= 1'b0;
      end
      else
      begin
         status <= (status & ~(status_clr ? {EV_W{1'b1}} : EV_NONE)) | ev_set;
         IRQ <= |(status & mask);
      end
   end

   always_ff @(posedge CORE_CLK)
   begin
      RD_DATA <= '0;
      if (RD_STB && !SYS_RST)
      begin
         unique case (ADDR)
            REG_CTRL: RD_DATA[CTRL_EN_BIT] <= ctrl_en;
            REG_STATUS: RD_DATA[EV_W-1:0] <= status;
            REG_MASK: RD_DATA[EV_W-1:0] <= mask;
            REG_CODE:
            begin
               RD_DATA[CODE_W-1:0] <= code;
               RD_DATA[CODE_STEER_BIT] <= EARLY_STEER_OUT;
               RD_DATA[CODE_CNT_LSB +: 3] <= bit_cnt;
            end
            default: RD_DATA <= '0;
         endcase
      end
   end

   // Run-length helpers for checking steering times
   always_ff @(posedge CORE_CLK)
   begin
      if (SYS_RST)
      begin
         det_run <= '0;
         abs_run <= '0;
      end
      else
      begin
         det_run <= (detect && code_ready && !code_changed) ? det_run + 1'b1 : '0;
         abs_run <= !detect ? abs_run + 1'b1 : '0;
      end
   end

   steer_cause_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      $rose(EARLY_STEER_OUT) |-> $past(detect) && $past(code_ready))
      else $error("steering rose without detect and code ready");

   presence_time_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      $rose(EARLY_STEER_OUT) |-> int'($past(det_run)) >= PRES_CYC - 1)
      else $error("steering rose before presence time");

   absence_time_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      $fell(EARLY_STEER_OUT) |-> int'($past(abs_run)) >= ABS_CYC - 1)
      else $error("steering fell before absence time");

   first_capture_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      (ack_rise && EARLY_STEER_OUT && sh_state == SH_ARMED && !steer_rise)
      |=> SERIAL_CODE_OUT == $past(code[0]) && shreg == $past(code))
      else $error("first acknowledge did not present bit zero");

   shift_step_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      (ack_rise && EARLY_STEER_OUT && sh_state == SH_SHIFT && !steer_rise)
      |=> SERIAL_CODE_OUT == shreg[$past(bit_cnt[1:0])])
      else $error("acknowledge did not advance serial bit");

   extra_ack_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      (sh_state == SH_WAIT && !steer_rise) |=> $stable(SERIAL_CODE_OUT))
      else $error("acknowledge past fourth changed serial output");

   steer_low_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      !EARLY_STEER_OUT |=> $stable(SERIAL_CODE_OUT))
      else $error("serial output moved while steering low");

   four_pulses_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      (sh_state == SH_SHIFT && bit_cnt == LAST_BIT && ack_rise && EARLY_STEER_OUT &&
       !steer_rise) |=> sh_state == SH_WAIT ##1 status[EV_DONE])
      else $error("fourth acknowledge did not end the digit");

   code_ready_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      detect |=> code_ready && code == tone2code($past(tone[GRP_ROW].idx),
                                                 $past(tone[GRP_COL].idx)))
      else $error("code not ready after detect");

endmodule

// file: dv/dtmfcs_host_model.sv
/*
 Host model: pulses the acknowledge pin and collects the serial code bits.
 Assumes the device samples the pin with its own clock and drives its outputs.
*/
`timescale 1ns/1ps
module dtmfcs_host_model
(
   // Device pins
   input wire logic EARLY_STEER_OUT,
   input wire logic SERIAL_CODE_OUT,
   output logic ACK
);
   initial ACK = 1'b0;

   // Link clock of 160 ns, still outside a burst; bit read before next rise
   task automatic burst(input int n, output logic [7:0] bits);
      bits = 8'h00;
      #7;
      for (int i = 0; i < n; i++)
      begin
         ACK = 1'b1;
         #80;
         ACK = 1'b0;
         #80;
         bits[i] = SERIAL_CODE_OUT;
      end
   endtask

   // Steering must stand high for a while before the digit is taken
   task automatic guard(output logic ok);
      ok = 1'b1;
      repeat (50)
      begin
         #20;
         ok = ok & EARLY_STEER_OUT;
      end
   endtask
endmodule

// file: dv/tb_dtmf_code_steering_serializer.sv
/*
 Self-checking bench: register reads, refused and accepted acknowledges,
 one hash digit from squared tones, steering fall on detector disable.
 Assumes the design package and the host model are compiled first.
*/
`timescale 1ns/1ps
module tb_dtmf_code_steering_serializer;
   import dtmfcs_pkg::*;
   localparam logic [31:0] all_ones = 32'hFFFF_FFFF;
   // Expected codes, row-major, one nibble per row and column pair
   localparam logic [63:0] codes = 64'h0CAB_F987_E654_D321;
   logic CORE_CLK = 1'b0;
   logic SYS_RST = 1'b1;
   logic ROW_TONE = 1'b0;
   logic COL_TONE = 1'b0;
   logic WR_STB = 1'b0;
   logic RD_STB = 1'b0;
   logic [ADDR_W-1:0] ADDR = 8'h00;
   logic [DATA_W-1:0] WR_DATA = 32'h0000_0000;
   logic [DATA_W-1:0] RD_DATA;
   logic EARLY_STEER_OUT;
   logic SERIAL_CODE_OUT;
   logic IRQ;
   logic ACK;
   logic tone_on = 1'b0;
   logic rd_pend = 1'b0;
   logic [31:0] exp_q[$];
   logic [31:0] msk_q[$];
   logic [31:0] seed = 32'hECAE24F8;
   logic [7:0] bits;
   logic ok;
   logic [31:0] got;
   int error_cnt = 0;
   int checks_done = 0;
   int cycles = 0;

   always #10 CORE_CLK = ~CORE_CLK;
   // Squared 941 Hz row and 1477 Hz column
   always #531349.6 if (tone_on) ROW_TONE = ~ROW_TONE;
   always #338524.0 if (tone_on) COL_TONE = ~COL_TONE;

   dtmfcs_top #(.PRES_CYC(50), .ABS_CYC(20)) dtmfcs_top_inst
   (
      .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .ROW_TONE(ROW_TONE), .COL_TONE(COL_TONE),
      .ACK(ACK), .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_STB(WR_STB), .RD_STB(RD_STB),
      .RD_DATA(RD_DATA), .EARLY_STEER_OUT(EARLY_STEER_OUT),
      .SERIAL_CODE_OUT(SERIAL_CODE_OUT), .IRQ(IRQ)
   );

   dtmfcs_host_model dtmfcs_host_model_inst
   (
      .EARLY_STEER_OUT(EARLY_STEER_OUT), .SERIAL_CODE_OUT(SERIAL_CODE_OUT), .ACK(ACK)
   );

   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic check(input string what, input logic [31:0] e, input logic [31:0] got);
      checks_done++;
      if (got !== e)
      begin
         $display("ERROR %s expected %h seen %h", what, e, got);
         error_cnt++;
      end
   endtask

   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge CORE_CLK);
      ADDR <= a;
      WR_DATA <= d;
      WR_STB <= 1'b1;
      @(posedge CORE_CLK);
      WR_STB <= 1'b0;
   endtask

   // Expected read value noted here, compared by the monitor
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      @(posedge CORE_CLK);
      ADDR <= a;
      RD_STB <= 1'b1;
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      @(posedge CORE_CLK);
      RD_STB <= 1'b0;
   endtask

   task automatic wait_est(input logic v);
      int n;
      n = 0;
      while (EARLY_STEER_OUT !== v && n < 150000)
      begin
         @(posedge CORE_CLK);
         n++;
      end
      check("EARLY_STEER_OUT", {31'h0, v}, {31'h0, EARLY_STEER_OUT});
   endtask

   always @(posedge CORE_CLK)
   begin
      rd_pend <= RD_STB;
      if (rd_pend && exp_q.size() > 0)
         check("RD_DATA", exp_q.pop_front(), RD_DATA & msk_q.pop_front());
   end

   always @(posedge CORE_CLK)
   begin
      cycles++;
      // One digit needs two row rising edges, one and a half row periods, about 80k cycles in all
      if (cycles == 90000)
      begin
         error_cnt++;
         $display("ERROR timeout expected finish seen hang");
         report_and_stop();
      end
   end

   initial
   begin
      repeat (2) @(posedge CORE_CLK);
      SYS_RST <= 1'b0;
      rd(REG_CTRL, 32'h0000_0001, all_ones);
      rd(REG_MASK, 32'h0000_0000, all_ones);
      rd(REG_STATUS, 32'h0000_0000, all_ones);
      seed = xorshift(seed);
      wr(8'h10, seed);
      rd(8'h10, 32'h0000_0000, all_ones);
      wr(REG_MASK, 32'h0000_000F);
      rd(REG_MASK, 32'h0000_000F, all_ones);
      for (int i = 0; i < 16; i++)
      begin
         got = {28'h0, tone2code(i[3:2], i[1:0])};
         check("code", {28'h0, codes[4*i +: 4]}, got);
      end
      $display("Test reset and map done");
      // Dummy acknowledges while steering is low leave the serial output alone and set the ignored event
      dtmfcs_host_model_inst.burst(4, bits);
      check("SERIAL_CODE_OUT", 32'h0, {24'h0, bits});
      repeat (3) @(posedge CORE_CLK);
      check("IRQ", 32'h1, {31'h0, IRQ});
      rd(REG_STATUS, 32'h0000_0008, all_ones);
      rd(REG_STATUS, 32'h0000_0000, all_ones);
      repeat (3) @(posedge CORE_CLK);
      check("IRQ", 32'h0, {31'h0, IRQ});
      $display("Test refused acknowledges done");
      // Hash digit after a random delay; tone edges still fall at fixed times
      seed = xorshift(seed);
      #(seed[15:0]);
      tone_on = 1'b1;
      wait_est(1'b1);
      repeat (3) @(posedge CORE_CLK);
      check("IRQ", 32'h1, {31'h0, IRQ});
      rd(REG_STATUS, 32'h0000_0001, all_ones);
      rd(REG_CODE, 32'h0000_001C, 32'h0000_001F);
      dtmfcs_host_model_inst.guard(ok);
      check("guard", 32'h1, {31'h0, ok});
      dtmfcs_host_model_inst.burst(5, bits);
      check("SERIAL_CODE_OUT", 32'h1C, {24'h0, bits});
      rd(REG_STATUS, 32'h0000_000C, all_ones);
      $display("Test digit shift done");
      // Detector disabled: steering falls, top bit holds
      wr(REG_CTRL, 32'h0000_0000);
      wait_est(1'b0);
      tone_on = 1'b0;
      rd(REG_STATUS, 32'h0000_0002, all_ones);
      check("SERIAL_CODE_OUT", 32'h1, {31'h0, SERIAL_CODE_OUT});
      repeat (3) @(posedge CORE_CLK);
      $display("Test steering fall done");
      report_and_stop();
   end
endmodule
